// [ctm_timer.sv]
// Compact 16-bit timer with compare-match, timer/counter and PWM modes.
//
// Operation
// - Mode field: 00 compare-match, 11 timer/counter, 10 PWM.
// - Clear-select low: clear on period match or wrap; raise A and P flags.
// - Clear-select high: clear on compare A match; raise only the A flag.
// - Clear-select high with compare A zero: wrap at FFFF, no A flag.
// - Compare-match pin responds to compare A match only, never to period match.
// - On A match the pin goes high, low or toggles; code zero keeps it.
// - Timer-on rising edge loads the pin with the initial-output level.
// - Timer/counter mode counts and flags like compare-match but releases the pin.
// - PWM ignores clear-select; one compare sets frequency, the other duty.
// - Duty/period swap chooses which compare is period and which is duty.
// - PWM raises A flag on each A match and P flag on each P match.
// - PWM output function enables the waveform or forces inactive or active.
// - Initial-output picks active level in PWM; invert bit flips the pin.
// - Swap zero: period is period value times 256, zero means 65536; duty is A.
// - Duty at or above period keeps the output active all period.
// - Swap one: period is compare A; duty is period value times 256, zero 65536.
// - PWM counting and flags continue while the pin is forced.
// - Period value is matched as the counter's upper eight bits, with the lower eight bits zero.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer
  import ctm_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic [ctm_pkg::CTM_ADDR_W-1:0] regAddr,
  input  wire logic [ctm_pkg::CTM_DATA_W-1:0] regWdata,
  input  wire logic                            regWrite,
  input  wire logic                            regRead,
  output var  logic [ctm_pkg::CTM_DATA_W-1:0] regRdata,
  output var  logic                            tpOut,
  output var  logic                            tpOeN,
  output var  logic                            matchAPulse,
  output var  logic                            matchPPulse,
  output var  logic                            matchAFlag,
  output var  logic                            matchPFlag
);

  logic                   timerOn;
  ctm_mode_e              modeSel;
  logic [1:0]             outFunc;
  logic                   initialOutput;
  logic                   outputInvert;
  logic                   dutyPeriodSwap;
  logic                   clearSelect;
  logic [CTM_CNT_W-1:0]   compareAValue;
  logic [CTM_PER_W-1:0]   periodCompareValue;
  logic [CTM_CNT_W-1:0]   count;
  logic                   cmpLevel;
  logic [CTM_CNT_W-1:0]   cntInc;
  logic [CTM_CNT_W-1:0]   next_count;
  logic                   aHit;
  logic                   pHit;
  logic                   isPwm;
  logic                   clearOnA;
  logic                   counterClear;
  logic                   onRise;
  logic                   wrCtrl0;
  logic                   wrCtrl1;
  logic                   wrFlags;
  logic                   wrCmpaLo;
  logic                   wrCmpaHi;
  logic                   wrPeriod;
  logic [CTM_DATA_W-1:0]  compareALo;
  logic [CTM_DATA_W-1:0]  compareAHi;
  logic                   aSet;
  logic                   pSet;
  logic [CTM_CNT_W:0]     dutyValue;
  logic                   pwmActive;
  logic                   next_cmpLevel;
  logic                   next_tpOut;
  logic                   pinDriven;
  logic [CTM_DATA_W-1:0]  next_regRdata;
  logic [CTM_NUM_FLAGS-1:0] flagSet;
  logic [CTM_NUM_FLAGS-1:0] flagClr;
  logic [CTM_NUM_FLAGS-1:0] flagVal;

  // Write decode.
  assign wrCtrl0 = regWrite && (regAddr == CTM_REG_CTRL0);
  assign wrCtrl1 = regWrite && (regAddr == CTM_REG_CTRL1);
  assign wrFlags = regWrite && (regAddr == CTM_REG_FLAGS);
  assign wrCmpaLo = regWrite && (regAddr == CTM_REG_CMPA_LO);
  assign wrCmpaHi = regWrite && (regAddr == CTM_REG_CMPA_HI);
  assign wrPeriod = regWrite && (regAddr == CTM_REG_PERIOD);

  // The on edge is taken from the write itself, so clearing and pin load land with it.
  assign onRise = wrCtrl0 && regWdata[CTM_CTRL0_ON_BIT] && !timerOn;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timerOn <= 1'b0;
    end else if (wrCtrl0) begin
      timerOn <= regWdata[CTM_CTRL0_ON_BIT];
    end
  end

  // Mode and output controls; changing them while running is left to software.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeSel <= ctm_mode_e'(CTM_CTRL1_RST[CTM_CTRL1_MODE_HI:CTM_CTRL1_MODE_LO]);
    end else if (wrCtrl1) begin
      modeSel <= ctm_mode_e'(regWdata[CTM_CTRL1_MODE_HI:CTM_CTRL1_MODE_LO]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outFunc       <= CTM_CTRL1_RST[CTM_CTRL1_OUTF_HI:CTM_CTRL1_OUTF_LO];
      initialOutput <= CTM_CTRL1_RST[CTM_CTRL1_INIT_BIT];
      outputInvert  <= CTM_CTRL1_RST[CTM_CTRL1_INV_BIT];
    end else if (wrCtrl1) begin
      outFunc       <= regWdata[CTM_CTRL1_OUTF_HI:CTM_CTRL1_OUTF_LO];
      initialOutput <= regWdata[CTM_CTRL1_INIT_BIT];
      outputInvert  <= regWdata[CTM_CTRL1_INV_BIT];
    end
  end

  // The swap and clear-select bits steer the counter; in PWM the swap bit also picks the duty that drives the pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dutyPeriodSwap <= CTM_CTRL1_RST[CTM_CTRL1_SWAP_BIT];
      clearSelect    <= CTM_CTRL1_RST[CTM_CTRL1_CLR_BIT];
    end else if (wrCtrl1) begin
      dutyPeriodSwap <= regWdata[CTM_CTRL1_SWAP_BIT];
      clearSelect    <= regWdata[CTM_CTRL1_CLR_BIT];
    end
  end

  // Compare A is written a byte at a time with no shadow, so a running match may see a torn value.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compareALo <= CTM_CMPA_RST[7:0];
    end else if (wrCmpaLo) begin
      compareALo <= regWdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compareAHi <= CTM_CMPA_RST[15:8];
    end else if (wrCmpaHi) begin
      compareAHi <= regWdata;
    end
  end

  assign compareAValue = {compareAHi, compareALo};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      periodCompareValue <= CTM_PERIOD_RST;
    end else if (wrPeriod) begin
      periodCompareValue <= regWdata;
    end
  end

  // Comparators look at the value the counter is about to take.
  assign cntInc = count + CTM_CNT_ONE;
  // A zero period value matches at the wrap, which gives the overflow clear.
  assign pHit = (cntInc == {periodCompareValue, CTM_P_LOW_ZERO});
  // A zero compare A value never matches, so the counter runs to FFFF.
  assign aHit = (cntInc == compareAValue) && (compareAValue != CTM_CNT_ZERO);
  assign isPwm = (modeSel == CTM_MODE_PWM);
  // In PWM the swap bit picks the clearing comparator and clear-select is unused.
  assign clearOnA = isPwm ? dutyPeriodSwap : clearSelect;
  assign counterClear = clearOnA ? aHit : pHit;

  always_comb begin
    if (onRise) begin
      next_count = CTM_CNT_ZERO;
    end else if (!timerOn) begin
      next_count = count;
    end else if (counterClear) begin
      next_count = CTM_CNT_ZERO;
    end else begin
      next_count = cntInc;
    end
  end

  // Counting goes on whatever the output function forces on the pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= CTM_CNT_RST;
    end else begin
      count <= next_count;
    end
  end

  // Flag events; the period flag is suppressed only by clear-select outside PWM.
  assign aSet = timerOn && aHit;
  assign pSet = timerOn && pHit && (isPwm || !clearSelect);

  assign flagSet[CTM_FLAG_A_BIT] = aSet;
  assign flagSet[CTM_FLAG_P_BIT] = pSet;

  generate
    for (genvar i = 0; i < CTM_NUM_FLAGS; i++) begin : gFlag
      assign flagClr[i] = wrFlags && regWdata[i];
      ctm_flag uFlag (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .setEvent (flagSet[i]),
        .clearReq (flagClr[i]),
        .flag     (flagVal[i])
      );
    end
  endgenerate

  assign matchAFlag = flagVal[CTM_FLAG_A_BIT];
  assign matchPFlag = flagVal[CTM_FLAG_P_BIT];

  // The pulses are registered like the flags, so both show a match in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      matchAPulse <= 1'b0;
      matchPPulse <= 1'b0;
    end else begin
      matchAPulse <= aSet;
      matchPPulse <= pSet;
    end
  end

  // Compare-match pin state, before the polarity inversion.
  always_comb begin
    next_cmpLevel = cmpLevel;
    if (onRise) begin
      next_cmpLevel = initialOutput;
    end else if ((modeSel == CTM_MODE_CMP) && aSet) begin
      case (outFunc)
        CTM_CMP_OF_LOW: begin
          next_cmpLevel = 1'b0;
        end
        CTM_CMP_OF_HIGH: begin
          next_cmpLevel = 1'b1;
        end
        CTM_CMP_OF_TOGGLE: begin
          next_cmpLevel = !cmpLevel;
        end
        default: begin
          next_cmpLevel = cmpLevel;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmpLevel <= 1'b0;
    end else begin
      cmpLevel <= next_cmpLevel;
    end
  end

  // Duty threshold; a zero period value stands for the full 65536 span.
  always_comb begin
    if (dutyPeriodSwap) begin
      if (periodCompareValue == CTM_PER_ZERO) begin
        dutyValue = CTM_FULL_SPAN;
      end else begin
        dutyValue = {1'b0, periodCompareValue, CTM_P_LOW_ZERO};
      end
    end else begin
      dutyValue = {1'b0, compareAValue};
    end
  end

  // The count never reaches the period, so a duty at or above it stays active.
  assign pwmActive = ({1'b0, count} < dutyValue);

  // The pin level is registered; in PWM it trails the count by one clock, in compare-match it switches with the count.
  always_comb begin
    next_tpOut = 1'b0;
    if (isPwm) begin
      case (outFunc)
        CTM_PWM_OF_WAVE: begin
          next_tpOut = pwmActive ? initialOutput : !initialOutput;
        end
        CTM_PWM_OF_ACTIVE: begin
          next_tpOut = initialOutput;
        end
        default: begin
          next_tpOut = !initialOutput;
        end
      endcase
      next_tpOut = next_tpOut ^ outputInvert;
    end else if (modeSel == CTM_MODE_CMP) begin
      next_tpOut = next_cmpLevel ^ outputInvert;
    end
  end

  // Only compare-match and PWM drive the pin; other modes release it.
  assign pinDriven = (modeSel == CTM_MODE_CMP) || isPwm;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tpOut <= 1'b0;
      tpOeN <= 1'b1;
    end else begin
      tpOut <= next_tpOut;
      tpOeN <= !pinDriven;
    end
  end

  // Read decode; unmapped offsets read zero.
  always_comb begin
    next_regRdata = CTM_RD_ZERO;
    if (regAddr == CTM_REG_CTRL0) begin
      next_regRdata[CTM_CTRL0_ON_BIT] = timerOn;
    end else if (regAddr == CTM_REG_CTRL1) begin
      next_regRdata = {modeSel, outFunc, initialOutput, outputInvert, dutyPeriodSwap, clearSelect};
    end else if (regAddr == CTM_REG_CNT_LO) begin
      next_regRdata = count[7:0];
    end else if (regAddr == CTM_REG_CNT_HI) begin
      next_regRdata = count[15:8];
    end else if (regAddr == CTM_REG_CMPA_LO) begin
      next_regRdata = compareAValue[7:0];
    end else if (regAddr == CTM_REG_CMPA_HI) begin
      next_regRdata = compareAValue[15:8];
    end else if (regAddr == CTM_REG_PERIOD) begin
      next_regRdata = periodCompareValue;
    end else if (regAddr == CTM_REG_FLAGS) begin
      next_regRdata[CTM_FLAG_A_BIT] = flagVal[CTM_FLAG_A_BIT];
      next_regRdata[CTM_FLAG_P_BIT] = flagVal[CTM_FLAG_P_BIT];
    end
  end

  // Read data fall back to zero outside the answer cycle, so a stale value never lingers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= CTM_RD_ZERO;
    end else if (regRead) begin
      regRdata <= next_regRdata;
    end else begin
      regRdata <= CTM_RD_ZERO;
    end
  end

endmodule
`default_nettype wire

// [ctm_pkg.sv]
// Constants, register map and field layout of the compact timer.
`default_nettype none
package ctm_pkg;

  localparam int CTM_ADDR_W = 4;
  localparam int CTM_DATA_W = 8;
  localparam int CTM_CNT_W  = 16;
  localparam int CTM_PER_W  = 8;

  // Register offsets.
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CTRL0   = 4'h0;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CTRL1   = 4'h1;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CNT_LO  = 4'h2;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CNT_HI  = 4'h3;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CMPA_LO = 4'h4;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_CMPA_HI = 4'h5;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_PERIOD  = 4'h6;
  localparam logic [CTM_ADDR_W-1:0] CTM_REG_FLAGS   = 4'h7;

  // Field positions.
  localparam int CTM_CTRL0_ON_BIT   = 3;
  localparam int CTM_CTRL1_MODE_HI  = 7;
  localparam int CTM_CTRL1_MODE_LO  = 6;
  localparam int CTM_CTRL1_OUTF_HI  = 5;
  localparam int CTM_CTRL1_OUTF_LO  = 4;
  localparam int CTM_CTRL1_INIT_BIT = 3;
  localparam int CTM_CTRL1_INV_BIT  = 2;
  localparam int CTM_CTRL1_SWAP_BIT = 1;
  localparam int CTM_CTRL1_CLR_BIT  = 0;
  localparam int CTM_FLAG_A_BIT     = 0;
  localparam int CTM_FLAG_P_BIT     = 1;
  localparam int CTM_NUM_FLAGS      = 2;

  // Reset values.
  localparam logic [CTM_DATA_W-1:0] CTM_CTRL1_RST  = 8'h00;
  localparam logic [CTM_CNT_W-1:0]  CTM_CMPA_RST   = 16'h0000;
  localparam logic [CTM_PER_W-1:0]  CTM_PERIOD_RST = 8'h00;
  localparam logic [CTM_CNT_W-1:0]  CTM_CNT_RST    = 16'h0000;
  localparam logic [CTM_DATA_W-1:0] CTM_RD_ZERO    = 8'h00;

  // Counting constants.
  localparam logic [CTM_CNT_W-1:0] CTM_CNT_ONE      = 16'h0001;
  localparam logic [CTM_CNT_W-1:0] CTM_CNT_ZERO     = 16'h0000;
  localparam logic [7:0]           CTM_P_LOW_ZERO   = 8'h00;
  localparam logic [CTM_PER_W-1:0] CTM_PER_ZERO     = 8'h00;
  localparam logic [CTM_CNT_W:0]   CTM_FULL_SPAN    = 17'h10000;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_CAP = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_e;

  // Output-function codes in compare-match mode.
  localparam logic [1:0] CTM_CMP_OF_NONE   = 2'h0;
  localparam logic [1:0] CTM_CMP_OF_LOW    = 2'h1;
  localparam logic [1:0] CTM_CMP_OF_HIGH   = 2'h2;
  localparam logic [1:0] CTM_CMP_OF_TOGGLE = 2'h3;

  // Output-function codes in PWM mode.
  localparam logic [1:0] CTM_PWM_OF_INACTIVE = 2'h0;
  localparam logic [1:0] CTM_PWM_OF_ACTIVE   = 2'h1;
  localparam logic [1:0] CTM_PWM_OF_WAVE     = 2'h2;

endpackage
`default_nettype wire

// [ctm_flag.sv]
// Sticky compare flag that software clears.
`timescale 1ns/100ps
`default_nettype none
module ctm_flag (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic setEvent,
  input  wire logic clearReq,
  output var  logic flag
);

  // A match in the clearing cycle still leaves the flag set.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (setEvent) begin
      flag <= 1'b1;
    end else if (clearReq) begin
      flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [ctm_timer_chk.sv]
// Concurrent checks on the compact timer ports.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_chk
  import ctm_pkg::*;
(
  input wire logic                            sys_clk,
  input wire logic                            rst,
  input wire logic [ctm_pkg::CTM_ADDR_W-1:0] regAddr,
  input wire logic [ctm_pkg::CTM_DATA_W-1:0] regWdata,
  input wire logic                            regWrite,
  input wire logic                            tpOut,
  input wire logic                            tpOeN,
  input wire logic                            matchAPulse,
  input wire logic                            matchPPulse,
  input wire logic                            matchAFlag,
  input wire logic                            matchPFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence flagWipe;
    regWrite && regAddr == CTM_REG_FLAGS && regWdata[CTM_FLAG_A_BIT];
  endsequence
  // The mode write must stand a cycle alone, as a later write may reclaim the pin.
  sequence tcSelect;
    regWrite && regAddr == CTM_REG_CTRL1 && regWdata[7:6] == 2'h3 ##1 !(regWrite && regAddr == CTM_REG_CTRL1);
  endsequence
  pulse_a_a: assert property (matchAPulse |-> matchAFlag) else $error("A pulse without A flag");
  pulse_p_a: assert property (matchPPulse |-> matchPFlag) else $error("P pulse without P flag");
  hold_a_a: assert property (matchAFlag |=> matchAFlag || $past(regWrite && regAddr == CTM_REG_FLAGS && regWdata[0]))
    else $error("A flag dropped without a clear");
  rise_a_a: assert property ($rose(matchAFlag) |-> matchAPulse) else $error("A flag set without pulse");
  rise_p_a: assert property ($rose(matchPFlag) |-> matchPPulse) else $error("P flag set without pulse");
  wipe_a_a: assert property (flagWipe |=> !matchAFlag || matchAPulse) else $error("A flag not cleared");
  tc_off_a: assert property (tcSelect |=> tpOeN) else $error("pin still driven in timer mode");
  tc_low_a: assert property (tpOeN |-> !tpOut) else $error("released pin not low");
endmodule
bind ctm_timer ctm_timer_chk i_ctm_timer_chk (.sys_clk, .rst, .regAddr, .regWdata, .regWrite, .tpOut, .tpOeN,
  .matchAPulse, .matchPPulse, .matchAFlag, .matchPFlag);
`default_nettype wire

// [ctm_timer_bench.sv]
// Self-checking bench of the compact timer with a cycle model.
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_bench;
  import ctm_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic [CTM_ADDR_W-1:0] regAddr = 4'h0;
  logic [CTM_DATA_W-1:0] regWdata = 8'h00;
  logic                  regWrite = 1'b0;
  logic                  regRead = 1'b0;
  logic [CTM_DATA_W-1:0] regRdata;
  logic                  tpOut, tpOeN, matchAPulse, matchPPulse, matchAFlag, matchPFlag;
  int                    bad_count = 0, n_compared = 0, cyc = 0;
  int                    cnt, on, c1, pc, ca, per, fa, fp, lvl, md, nx, am, pm, duty, act, of;
  int                    eRd, eOut, eOe, ePA, ePP;

  ctm_timer i_ctm_timer (.sys_clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .tpOut, .tpOeN, .matchAPulse, .matchPPulse, .matchAFlag, .matchPFlag);

  initial forever #25 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("mismatches %0d compared %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input int exp);
    n_compared++;
    if (got !== exp[7:0]) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp[7:0]);
    end
  endtask

  // Model inputs are the values before the edge, since the bench drives by non-blocking assignment.
  always @(posedge sys_clk) begin
    cyc++;
    if (rst) begin
      cnt = 0; on = 0; c1 = 0; ca = 0; per = 0; fa = 0; fp = 0; lvl = 0;
      eRd = 0; eOut = 0; eOe = 1; ePA = 0; ePP = 0;
    end else begin
      pc = c1;
      md = c1 >> 6;
      of = (c1 >> 4) & 3;
      nx = (cnt + 1) & 'hffff;
      pm = on && nx == per * 256;
      am = on && ca != 0 && nx == ca;
      ePA = am;
      ePP = pm && !(md != 2 && (c1 & 1));
      duty = (c1 & 2) ? (per == 0 ? 65536 : per * 256) : ca;
      act = of == 2 ? cnt < duty : of == 1;
      eRd = 0;
      if (regRead) case (regAddr)
        0: eRd = on * 8;
        1: eRd = c1;
        2: eRd = cnt & 255;
        3: eRd = cnt >> 8;
        4: eRd = ca & 255;
        5: eRd = ca >> 8;
        6: eRd = per;
        7: eRd = fa + 2 * fp;
        default: eRd = 0;
      endcase
      fa = (fa && !(regWrite && regAddr == 7 && regWdata[0])) || ePA;
      fp = (fp && !(regWrite && regAddr == 7 && regWdata[1])) || ePP;
      if (ePA && md == 0) case (of)
        1: lvl = 0;
        2: lvl = 1;
        3: lvl = !lvl;
        default: ;
      endcase
      if (on) cnt = (((md == 2) ? (c1 & 2) : (c1 & 1)) != 0 ? am : pm) ? 0 : nx;
      if (regWrite) case (regAddr)
        0: begin
          if (regWdata[3] && !on) begin
            cnt = 0;
            lvl = (c1 >> 3) & 1;
          end
          on = regWdata[3];
        end
        1: c1 = regWdata;
        4: ca = (ca & 'hff00) | regWdata;
        5: ca = (ca & 255) | (regWdata << 8);
        6: per = regWdata;
        default: ;
      endcase
      eOe = !(md == 0 || md == 2);
      eOut = md == 0 ? lvl ^ ((pc >> 2) & 1) : md == 2 ? (act ^ !((pc >> 3) & 1)) ^ ((pc >> 2) & 1) : 0;
    end
    if (cyc == 90000) begin
      bad_count++;
      conclude();
    end
  end

  // Pin levels come from the controls held before the edge, so a control write shows one clock later.
  always @(negedge sys_clk) if (cyc > 0) begin
    chk(regRdata, eRd);
    chk(tpOut, eOut);
    chk(tpOeN, eOe);
    chk(matchAFlag, fa);
    chk(matchPFlag, fp);
    chk(matchAPulse, ePA);
    chk(matchPPulse, ePP);
  end

  task automatic put(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
  endtask

  task automatic cfg(input logic [7:0] ctl, input int a, input int p);
    put(1'b1, CTM_REG_CTRL0, 8'h00);
    put(1'b1, CTM_REG_CTRL1, ctl);
    put(1'b1, CTM_REG_CMPA_LO, a[7:0]);
    put(1'b1, CTM_REG_CMPA_HI, a[15:8]);
    put(1'b1, CTM_REG_PERIOD, p[7:0]);
    put(1'b1, CTM_REG_CTRL0, 8'h08);
  endtask

  task automatic run(input int n);
    int r;
    repeat (n) begin
      r = $urandom_range(0, 7);
      @(posedge sys_clk);
      regRead <= r == 0;
      regWrite <= r == 1;
      regAddr <= r == 1 ? CTM_REG_FLAGS : 4'($urandom_range(0, 15));
      regWdata <= 8'($urandom);
    end
  endtask

  initial begin
    int k;
    void'($urandom(32'ha72c));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    put(1'b1, CTM_REG_CNT_LO, 8'h55);
    for (k = 0; k < 16; k++) put(1'b0, 4'(k), 8'h00);
    for (k = 0; k < 4; k++) begin
      cfg({2'b00, 2'(k), 1'($urandom), 1'($urandom), 2'b00}, $urandom_range(1, 255), 1);
      run(600);
    end
    cfg(8'h31, 300, 1);
    run(700);
    cfg(8'hc1, 0, 0);
    run(66000);
    cfg(8'hc0, 50, 1);
    run(600);
    cfg(8'hae, 700, 0);
    run(1500);
    for (k = 0; k < 8; k++) begin
      cfg({2'b10, 2'(k), 2'($urandom), k[2], 1'($urandom)}, $urandom_range(1, 600), $urandom_range(1, 2));
      run(900);
    end
    put(1'b0, CTM_REG_FLAGS, 8'h00);
    @(posedge sys_clk);
    regRead <= 1'b0;
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule
`default_nettype wire
